// ===== core/dts_defines.svh
// Register indices, field positions, reset values and fixed codes of the debug/trigger/security CSR bank
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

// Register indices; the APB byte address is four times the index
`define DTS_IDX_SECCFG      12'h747
`define DTS_IDX_SECCFGH     12'h757
`define DTS_IDX_TSELECT     12'h7a0
`define DTS_IDX_TCONFIG     12'h7a1
`define DTS_IDX_TADDR       12'h7a2
`define DTS_IDX_TEXTRA      12'h7a3
`define DTS_IDX_MCONTEXT    12'h7a8
`define DTS_IDX_SCONTEXT    12'h7aa
`define DTS_IDX_DBGCTRL     12'h7b0
`define DTS_IDX_DBGPC       12'h7b1
`define DTS_IDX_SCRATCHA    12'h7b2
`define DTS_IDX_SCRATCHB    12'h7b3
`define DTS_IDX_CPUCTRL     12'h7c0

// Security configuration fields
`define DTS_SEC_BYPASS      2
`define DTS_SEC_DENY        1
`define DTS_SEC_LOCKDOWN    0

// Trigger configuration: fixed image and the armed-dependent bits
`define DTS_TCFG_RESET      32'h2800_1000
`define DTS_TCFG_MBIT       6
`define DTS_TCFG_UBIT       4
`define DTS_TCFG_EXEC       3

// Debug control fields
`define DTS_DCSR_RESET      32'h4000_0003
`define DTS_DCSR_VER        32'h4000_0000
`define DTS_DCSR_EBM        15
`define DTS_DCSR_EBU        12
`define DTS_DCSR_CAUSE_HI   8
`define DTS_DCSR_CAUSE_LO   6
`define DTS_DCSR_STEP       2
`define DTS_DCSR_PRV_HI     1

// CPU control fields
`define DTS_CPU_DFAULT      7
`define DTS_CPU_EXCSEEN     6
`define DTS_CPU_MASK_HI     5
`define DTS_CPU_MASK_LO     3
`define DTS_CPU_DUMMY       2
`define DTS_CPU_DIT         1
`define DTS_CPU_ICACHE      0

`endif

// ===== core/dts_pkg.sv
// Shared types of the debug/trigger/security CSR bank
package dts_pkg;
  typedef enum logic [1:0] {
    DTS_PRIV_USER    = 2'h0,
    DTS_PRIV_MACHINE = 2'h3
  } dts_priv_t;

  typedef enum logic [2:0] {
    DTS_CAUSE_NONE    = 3'h0,
    DTS_CAUSE_EBREAK  = 3'h1,
    DTS_CAUSE_TRIGGER = 3'h2,
    DTS_CAUSE_HALT    = 3'h3,
    DTS_CAUSE_STEP    = 3'h4
  } dts_cause_t;
endpackage

// ===== core/dts_csr_bank.sv
// Debug, trigger, security configuration and CPU control register bank with APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "dts_defines.svh"

module dts_csr_bank #(
  parameter bit ProtectionPresent     = 1'b1,
  parameter bit TriggerSupportOn      = 1'b1,
  parameter int TriggerCountParam     = 1,
  parameter bit SecurityFeaturesParam = 1'b1,
  parameter bit IcachePresent         = 1'b1
) (
  input  wire logic        ref_clk,            // Core clock, 200 MHz
  input  wire logic        reset,              // Synchronous reset, active high
  input  wire logic        clkEn,              // Freezes all state while low
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB access phase
  input  wire logic        pwrite,             // APB write
  input  wire logic [13:0] paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error: illegal or unmapped
  output logic             illegalAccess,      // Illegal instruction request
  input  wire logic        debugMode,          // Core is in debug mode
  input  wire logic [1:0]  curPriv,            // Current privilege level
  input  wire logic        debugEntry,         // Pulse: core enters debug mode
  input  wire logic [2:0]  debugCause,         // Cause code with the entry pulse
  input  wire logic [31:0] entryPc,            // Next PC with the entry pulse
  input  wire logic        ebreakExec,         // EBREAK being executed
  input  wire logic        syncException,      // Pulse: synchronous exception taken
  input  wire logic        mretExec,           // Pulse: machine return executed
  input  wire logic        fetchValid,         // Fetched instruction valid
  input  wire logic [31:0] fetchAddr,          // Fetched instruction address
  output logic             triggerHit,         // Break before fetched instruction
  output logic             ebreakToDebug,      // EBREAK enters debug, not trap
  output logic             stepEnable,         // Single step on resume
  output logic      [1:0]  debugPrv,           // Privilege to resume in
  output logic      [31:0] resumePc,           // PC loaded on resume
  output logic             lockBypass,         // Locked regions may be modified
  output logic             machineDefaultDeny, // Deny unmatched machine accesses
  output logic             machineLockdown,    // Enhanced region interpretation
  output logic             icacheEnable,       // Instruction cache on
  output logic             dataIndTiming,      // Data-independent timing on
  output logic             dummyInstrEn,       // Dummy instruction insertion on
  output logic      [2:0]  dummyInstrMask      // Dummy instruction frequency
);

  localparam int TrigN = (TriggerCountParam < 1) ? 1 : TriggerCountParam;
  localparam int IdxW  = (TrigN > 1) ? $clog2(TrigN) : 1;
  localparam logic [31:0] TrigMax = 32'(TrigN - 1);

  // Decoded result of one access: {mapped, allowed}
  function automatic logic [1:0] decodeAccess(input logic [11:0] idx, input logic dbg, input logic [1:0] prv);
    logic mach;
    logic trigOk;
    mach   = (prv == dts_pkg::DTS_PRIV_MACHINE);
    trigOk = TriggerSupportOn && (dbg || mach);
    case (idx)
      `DTS_IDX_SECCFG, `DTS_IDX_SECCFGH: decodeAccess = {1'b1, ProtectionPresent && mach};
      `DTS_IDX_TSELECT, `DTS_IDX_TCONFIG, `DTS_IDX_TADDR,
      `DTS_IDX_TEXTRA, `DTS_IDX_MCONTEXT, `DTS_IDX_SCONTEXT: decodeAccess = {1'b1, trigOk};
      `DTS_IDX_DBGCTRL, `DTS_IDX_DBGPC,
      `DTS_IDX_SCRATCHA, `DTS_IDX_SCRATCHB: decodeAccess = {1'b1, dbg};
      `DTS_IDX_CPUCTRL: decodeAccess = {1'b1, mach};
      default: decodeAccess = 2'b00;
    endcase
  endfunction

  // Only machine and user privilege are legal values
  function automatic logic prvLegal(input logic [1:0] p);
    prvLegal = (p == dts_pkg::DTS_PRIV_MACHINE) || (p == dts_pkg::DTS_PRIV_USER);
  endfunction

  logic [11:0] accIdx;
  logic [1:0]  accDec;
  logic        accOk;
  logic        wrStrobe;

  assign accIdx   = paddr[13:2];
  assign accDec   = decodeAccess(accIdx, debugMode, curPriv);
  assign accOk    = accDec[1] && accDec[0];
  assign pready   = psel && penable && clkEn;
  assign wrStrobe = pready && pwrite && accOk;

  // ---------------- Register state ----------------
  logic [2:0]  secCfg_reg,    secCfg_next;
  logic [31:0] trigIndex_reg, trigIndex_next;
  logic [31:0] matchAddr_reg [TrigN];
  logic [31:0] matchAddr_next[TrigN];
  logic        armed_reg     [TrigN];
  logic        armed_next    [TrigN];
  logic        ebm_reg,  ebm_next;
  logic        ebu_reg,  ebu_next;
  logic        step_reg, step_next;
  logic [2:0]  cause_reg, cause_next;
  logic [1:0]  prv_reg,  prv_next;
  logic [31:0] dpc_reg,  dpc_next;
  logic [31:0] scrA_reg, scrA_next;
  logic [31:0] scrB_reg, scrB_next;
  logic [7:0]  cpu_reg,  cpu_next;
  logic [IdxW-1:0] selIdx;

  assign selIdx = trigIndex_reg[IdxW-1:0];

  always_comb begin
    secCfg_next    = secCfg_reg;
    trigIndex_next = trigIndex_reg;
    for (int i = 0; i < TrigN; i++) begin
      matchAddr_next[i] = matchAddr_reg[i];
      armed_next[i]     = armed_reg[i];
    end
    ebm_next   = ebm_reg;
    ebu_next   = ebu_reg;
    step_next  = step_reg;
    cause_next = cause_reg;
    prv_next   = prv_reg;
    dpc_next   = dpc_reg;
    scrA_next  = scrA_reg;
    scrB_next  = scrB_reg;
    cpu_next   = cpu_reg;

    if (wrStrobe) begin
      case (accIdx)
        `DTS_IDX_SECCFG: secCfg_next = pwdata[2:0];
        `DTS_IDX_TSELECT: begin
          trigIndex_next = (pwdata >= 32'(TrigN)) ? TrigMax : pwdata;
        end
        `DTS_IDX_TCONFIG: begin
          if (debugMode) begin
            armed_next[selIdx] = pwdata[`DTS_TCFG_EXEC];
          end
        end
        `DTS_IDX_TADDR: begin
          if (debugMode) begin
            matchAddr_next[selIdx] = pwdata;
          end
        end
        `DTS_IDX_DBGCTRL: begin
          ebm_next  = pwdata[`DTS_DCSR_EBM];
          ebu_next  = pwdata[`DTS_DCSR_EBU];
          step_next = pwdata[`DTS_DCSR_STEP];
          if (prvLegal(pwdata[`DTS_DCSR_PRV_HI:0])) begin
            prv_next = pwdata[`DTS_DCSR_PRV_HI:0];
          end
        end
        `DTS_IDX_DBGPC:    dpc_next  = pwdata;
        `DTS_IDX_SCRATCHA: scrA_next = pwdata;
        `DTS_IDX_SCRATCHB: scrB_next = pwdata;
        `DTS_IDX_CPUCTRL: begin
          cpu_next[`DTS_CPU_DFAULT]  = pwdata[`DTS_CPU_DFAULT];
          cpu_next[`DTS_CPU_EXCSEEN] = pwdata[`DTS_CPU_EXCSEEN];
          if (SecurityFeaturesParam) begin
            cpu_next[`DTS_CPU_MASK_HI:`DTS_CPU_DIT] = pwdata[`DTS_CPU_MASK_HI:`DTS_CPU_DIT];
          end
          if (IcachePresent) begin
            cpu_next[`DTS_CPU_ICACHE] = pwdata[`DTS_CPU_ICACHE];
          end
        end
        // High security half, extra data and contexts drop writes
        default: ;
      endcase
    end

    // Hardware events come after software writes so they win over them; an exception set wins over a return clear
    if (mretExec) begin
      cpu_next[`DTS_CPU_EXCSEEN] = 1'b0;
    end
    if (syncException) begin
      if (cpu_reg[`DTS_CPU_EXCSEEN]) begin
        cpu_next[`DTS_CPU_DFAULT] = 1'b1;
      end
      cpu_next[`DTS_CPU_EXCSEEN] = 1'b1;
    end

    // Entry capture overrides a debugger write in the same cycle
    if (debugEntry) begin
      cause_next = debugCause;
      prv_next   = prvLegal(curPriv) ? curPriv : dts_pkg::DTS_PRIV_MACHINE;
      dpc_next   = entryPc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      secCfg_reg    <= 3'h0;
      trigIndex_reg <= 32'h0;
      for (int i = 0; i < TrigN; i++) begin
        matchAddr_reg[i] <= 32'h0;
        armed_reg[i]     <= 1'b0;
      end
      ebm_reg   <= 1'b0;
      ebu_reg   <= 1'b0;
      step_reg  <= 1'b0;
      cause_reg <= dts_pkg::DTS_CAUSE_NONE;
      prv_reg   <= dts_pkg::DTS_PRIV_MACHINE;
      dpc_reg   <= 32'h0;
      scrA_reg  <= 32'h0;
      scrB_reg  <= 32'h0;
      cpu_reg   <= 8'h0;
    end else if (clkEn) begin
      secCfg_reg    <= secCfg_next;
      trigIndex_reg <= trigIndex_next;
      for (int i = 0; i < TrigN; i++) begin
        matchAddr_reg[i] <= matchAddr_next[i];
        armed_reg[i]     <= armed_next[i];
      end
      ebm_reg   <= ebm_next;
      ebu_reg   <= ebu_next;
      step_reg  <= step_next;
      cause_reg <= cause_next;
      prv_reg   <= prv_next;
      dpc_reg   <= dpc_next;
      scrA_reg  <= scrA_next;
      scrB_reg  <= scrB_next;
      cpu_reg   <= cpu_next;
    end
  end

  // ---------------- Read path, sampled in the APB setup cycle ----------------
  logic [31:0] rdData_reg, rdData_next;
  logic        rdErr_reg,  rdErr_next;
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0;
    case (accIdx)
      `DTS_IDX_SECCFG:  rdMux = {29'h0, secCfg_reg};
      `DTS_IDX_TSELECT: rdMux = trigIndex_reg;
      `DTS_IDX_TCONFIG: begin
        rdMux = `DTS_TCFG_RESET;
        rdMux[`DTS_TCFG_MBIT] = armed_reg[selIdx];
        rdMux[`DTS_TCFG_UBIT] = armed_reg[selIdx];
        rdMux[`DTS_TCFG_EXEC] = armed_reg[selIdx];
      end
      `DTS_IDX_TADDR:   rdMux = matchAddr_reg[selIdx];
      `DTS_IDX_DBGCTRL: begin
        rdMux = `DTS_DCSR_VER;
        rdMux[`DTS_DCSR_EBM] = ebm_reg;
        rdMux[`DTS_DCSR_EBU] = ebu_reg;
        rdMux[`DTS_DCSR_CAUSE_HI:`DTS_DCSR_CAUSE_LO] = cause_reg;
        rdMux[`DTS_DCSR_STEP] = step_reg;
        rdMux[`DTS_DCSR_PRV_HI:0] = prv_reg;
      end
      `DTS_IDX_DBGPC:    rdMux = dpc_reg;
      `DTS_IDX_SCRATCHA: rdMux = scrA_reg;
      `DTS_IDX_SCRATCHB: rdMux = scrB_reg;
      `DTS_IDX_CPUCTRL:  rdMux = {24'h0, cpu_reg};
      default:           rdMux = 32'h0;
    endcase
  end

  always_comb begin
    rdData_next = rdData_reg;
    rdErr_next  = rdErr_reg;
    if (psel && !penable) begin
      rdData_next = accOk ? rdMux : 32'h0;
      rdErr_next  = !accOk;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdData_reg <= 32'h0;
      rdErr_reg  <= 1'b0;
    end else if (clkEn) begin
      rdData_reg <= rdData_next;
      rdErr_reg  <= rdErr_next;
    end
  end

  assign prdata        = rdData_reg;
  assign pslverr       = pready && rdErr_reg;
  assign illegalAccess = pslverr;

  // ---------------- Outputs to the core ----------------
  logic anyHit;
  always_comb begin
    anyHit = 1'b0;
    for (int i = 0; i < TrigN; i++) begin
      if (armed_reg[i] && fetchAddr == matchAddr_reg[i]) begin
        anyHit = 1'b1;
      end
    end
  end

  // Hit is combinational so the core can stop before the instruction issues
  assign triggerHit    = TriggerSupportOn && fetchValid && !debugMode && anyHit;
  assign ebreakToDebug = ebreakExec && ((curPriv == dts_pkg::DTS_PRIV_MACHINE && ebm_reg) ||
                                        (curPriv == dts_pkg::DTS_PRIV_USER && ebu_reg));
  assign stepEnable         = step_reg;
  assign debugPrv           = prv_reg;
  assign resumePc           = dpc_reg;
  assign lockBypass         = secCfg_reg[`DTS_SEC_BYPASS];
  assign machineDefaultDeny = secCfg_reg[`DTS_SEC_DENY];
  assign machineLockdown    = secCfg_reg[`DTS_SEC_LOCKDOWN];
  assign icacheEnable       = cpu_reg[`DTS_CPU_ICACHE];
  assign dataIndTiming      = cpu_reg[`DTS_CPU_DIT];
  assign dummyInstrEn       = cpu_reg[`DTS_CPU_DUMMY];
  assign dummyInstrMask     = cpu_reg[`DTS_CPU_MASK_HI:`DTS_CPU_MASK_LO];

  // ---------------- Assertions ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || !clkEn);

  sequence apbSetup(logic [11:0] idx);
    psel && !penable && paddr[13:2] == idx;
  endsequence

  sequence apbDone;
    psel && penable && clkEn;
  endsequence

  seccfg_high_zero_a: assert property (apbSetup(`DTS_IDX_SECCFGH) ##1 apbDone |-> prdata == 32'h0)
    else $error("high security half did not read zero");

  tindex_clamp_a: assert property (wrStrobe && accIdx == `DTS_IDX_TSELECT && pwdata >= 32'(TrigN)
                                   |=> trigIndex_reg == TrigMax)
    else $error("trigger index not clamped");

  tdata_mmode_ignore_a: assert property (wrStrobe && accIdx == `DTS_IDX_TADDR && !debugMode && !reset
                                         |=> $stable(matchAddr_reg[selIdx]))
    else $error("machine-mode trigger address write took effect");

  dcsr_debug_only_a: assert property (psel && !penable && paddr[13:2] == `DTS_IDX_DBGCTRL && !debugMode
                                      ##1 apbDone |-> pslverr)
    else $error("debug control reachable outside debug mode");

  // Only bits 6, 4 and 3 may move; every other field is fixed
  tcfg_fixed_a: assert property (apbSetup(`DTS_IDX_TCONFIG) ##1 apbDone && !pslverr
                                 |-> (prdata & ~32'h0000_0058) == `DTS_TCFG_RESET)
    else $error("trigger config fixed fields changed");

  cause_capture_a: assert property (debugEntry |=> cause_reg == $past(debugCause))
    else $error("debug cause not recorded");

  prv_legal_a: assert property (prv_reg == dts_pkg::DTS_PRIV_MACHINE || prv_reg == dts_pkg::DTS_PRIV_USER)
    else $error("illegal privilege stored");

  dpc_capture_a: assert property (debugEntry |=> resumePc == $past(entryPc))
    else $error("debug PC not captured");

  dfault_set_a: assert property (syncException && cpu_reg[`DTS_CPU_EXCSEEN] |=> cpu_reg[`DTS_CPU_DFAULT])
    else $error("double fault not flagged");

  excseen_flow_a: assert property (mretExec && !syncException |=> !cpu_reg[`DTS_CPU_EXCSEEN])
    else $error("exception-seen not cleared by return");

endmodule

// ===== test/dts_core_model.sv
// Behavioural model of the core side: mode, privilege, debug entry, exceptions and fetch
`timescale 1ns/10ps
module dts_core_model (
  input  wire logic        ref_clk,       // Core clock
  output logic             debugMode,     // Core in debug mode
  output logic      [1:0]  curPriv,       // Current privilege
  output logic             debugEntry,    // Debug entry pulse
  output logic      [2:0]  debugCause,    // Entry cause
  output logic      [31:0] entryPc,       // Next PC at entry
  output logic             ebreakExec,    // EBREAK executing
  output logic             syncException, // Exception pulse
  output logic             mretExec,      // Machine return pulse
  output logic             fetchValid,    // Fetch valid
  output logic      [31:0] fetchAddr      // Fetch address
);
  initial begin
    debugMode = 1'b0;
    curPriv = 2'h3;
    debugEntry = 1'b0;
    debugCause = 3'h0;
    entryPc = 32'h0000_0000;
    ebreakExec = 1'b0;
    syncException = 1'b0;
    mretExec = 1'b0;
    fetchValid = 1'b0;
    fetchAddr = 32'h0000_0000;
  end
  // Only machine and user levels exist on this core
  task automatic setMode(input logic dbg, input logic [1:0] prv);
    @(posedge ref_clk);
    debugMode <= dbg;
    curPriv <= prv;
  endtask
  // Cause and PC are only meaningful with the pulse; scrambled afterwards
  task automatic enter(input logic [2:0] cause, input logic [31:0] pc);
    @(posedge ref_clk);
    debugEntry <= 1'b1;
    debugCause <= cause;
    entryPc <= pc;
    @(posedge ref_clk);
    debugEntry <= 1'b0;
    debugCause <= ~cause;
    entryPc <= ~pc;
    debugMode <= 1'b1;
  endtask
  task automatic pulse(input logic isMret);
    @(posedge ref_clk);
    syncException <= !isMret;
    mretExec <= isMret;
    @(posedge ref_clk);
    syncException <= 1'b0;
    mretExec <= 1'b0;
  endtask
  task automatic fetch(input logic vld, input logic [31:0] a);
    @(posedge ref_clk);
    fetchValid <= vld;
    fetchAddr <= a;
  endtask
  task automatic ebreak(input logic on);
    @(posedge ref_clk);
    ebreakExec <= on;
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the debug, trigger, security and CPU control register bank
`timescale 1ns/10ps
`include "dts_defines.svh"
module tb_top;
  localparam int NTRIG = 4;
  typedef struct packed {logic rd; logic err; logic [31:0] dat;} dts_exp_t;
  logic        ref_clk, reset, clkEn, psel, penable, pwrite, pready, pslverr, illegalAccess;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, entryPc, fetchAddr, resumePc, rnd, tAddr;
  logic        debugMode, debugEntry, ebreakExec, syncException, mretExec, fetchValid;
  logic [1:0]  curPriv, debugPrv;
  logic [2:0]  debugCause, dummyInstrMask;
  logic        triggerHit, ebreakToDebug, stepEnable, lockBypass, machineDefaultDeny;
  logic        machineLockdown, icacheEnable, dataIndTiming, dummyInstrEn;
  int          failures, nCompared;
  dts_exp_t    expQ[$];
  dts_exp_t    e;
  logic [11:0] idxTab[12] = '{`DTS_IDX_SECCFG, `DTS_IDX_SECCFGH, `DTS_IDX_TSELECT, `DTS_IDX_TCONFIG,
    `DTS_IDX_TADDR, `DTS_IDX_TEXTRA, `DTS_IDX_MCONTEXT, `DTS_IDX_SCONTEXT, `DTS_IDX_DBGCTRL,
    `DTS_IDX_DBGPC, `DTS_IDX_SCRATCHA, `DTS_IDX_SCRATCHB};
  logic [11:0] dbgTab[3] = '{`DTS_IDX_DBGPC, `DTS_IDX_SCRATCHA, `DTS_IDX_SCRATCHB};
  logic [11:0] zeroTab[3] = '{`DTS_IDX_TEXTRA, `DTS_IDX_MCONTEXT, `DTS_IDX_SCONTEXT};

  dts_csr_bank #(.TriggerCountParam(NTRIG)) dut (
    .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .illegalAccess(illegalAccess), .debugMode(debugMode), .curPriv(curPriv), .debugEntry(debugEntry),
    .debugCause(debugCause), .entryPc(entryPc), .ebreakExec(ebreakExec), .syncException(syncException),
    .mretExec(mretExec), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .triggerHit(triggerHit),
    .ebreakToDebug(ebreakToDebug), .stepEnable(stepEnable), .debugPrv(debugPrv), .resumePc(resumePc),
    .lockBypass(lockBypass), .machineDefaultDeny(machineDefaultDeny), .machineLockdown(machineLockdown),
    .icacheEnable(icacheEnable), .dataIndTiming(dataIndTiming), .dummyInstrEn(dummyInstrEn),
    .dummyInstrMask(dummyInstrMask));

  dts_core_model core (
    .ref_clk(ref_clk), .debugMode(debugMode), .curPriv(curPriv), .debugEntry(debugEntry),
    .debugCause(debugCause), .entryPc(entryPc), .ebreakExec(ebreakExec), .syncException(syncException),
    .mretExec(mretExec), .fetchValid(fetchValid), .fetchAddr(fetchAddr));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", failures, nCompared);
    if (failures == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Master holds the whole request until pready is seen high or 50 access cycles pass
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd, input logic err,
                     input logic [31:0] want);
    int n;
    expQ.push_back('{rd: !wr, err: err, dat: want});
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic err);
    apb(1'b1, idx, d, err, 32'h0000_0000);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] want, input logic err);
    apb(1'b0, idx, 32'h0000_0000, err, want);
  endtask

  task automatic settle;
    @(negedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("[ERR] %0t unexpected transfer", $time);
      end else begin
        e = expQ.pop_front();
        check(pslverr, e.err);
        check(illegalAccess, e.err);
        if (e.rd && !e.err) check(prdata, e.dat);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end

  initial begin
    clkEn = 1'b1;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    rnd = 32'h0000_0028;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    core.setMode(1'b1, 2'h3);
    foreach (idxTab[i]) rd(idxTab[i], (i == 3) ? `DTS_TCFG_RESET : (i == 8) ? `DTS_DCSR_RESET : 32'h0, 1'b0);
    wr(`DTS_IDX_SECCFG, 32'h0000_0007, 1'b0);
    settle();
    check(lockBypass, 1'b1);
    check(machineDefaultDeny, 1'b1);
    check(machineLockdown, 1'b1);
    wr(`DTS_IDX_SECCFG, 32'h0000_0004, 1'b0);
    rd(`DTS_IDX_SECCFG, 32'h0000_0004, 1'b0);
    settle();
    check({lockBypass, machineDefaultDeny, machineLockdown}, 3'h4);
    wr(`DTS_IDX_SECCFGH, 32'hffff_ffff, 1'b0);
    rd(`DTS_IDX_SECCFGH, 32'h0000_0000, 1'b0);
    wr(`DTS_IDX_TSELECT, 32'h0000_0009, 1'b0);
    rd(`DTS_IDX_TSELECT, NTRIG - 1, 1'b0);
    wr(`DTS_IDX_TSELECT, 32'h0000_0002, 1'b0);
    rd(`DTS_IDX_TSELECT, 32'h0000_0002, 1'b0);
    wr(`DTS_IDX_TSELECT, 32'h0000_0000, 1'b0);
    rd(12'h7a4, 32'h0000_0000, 1'b1);
    rnd = nextRnd(rnd);
    tAddr = {rnd[31:2], 2'b00};
    core.setMode(1'b0, 2'h3);
    // Machine mode outside debug may read but not arm triggers
    wr(`DTS_IDX_TADDR, tAddr, 1'b0);
    wr(`DTS_IDX_TCONFIG, 32'hffff_ffff, 1'b0);
    rd(`DTS_IDX_TADDR, 32'h0000_0000, 1'b0);
    rd(`DTS_IDX_TCONFIG, `DTS_TCFG_RESET, 1'b0);
    core.setMode(1'b0, 2'h0);
    rd(`DTS_IDX_TSELECT, 32'h0000_0000, 1'b1);
    rd(`DTS_IDX_SECCFG, 32'h0000_0000, 1'b1);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_0000, 1'b1);
    core.setMode(1'b0, 2'h3);
    foreach (dbgTab[i]) rd(dbgTab[i], 32'h0000_0000, 1'b1);
    rd(`DTS_IDX_DBGCTRL, 32'h0000_0000, 1'b1);
    core.setMode(1'b1, 2'h3);
    wr(`DTS_IDX_TADDR, tAddr, 1'b0);
    wr(`DTS_IDX_TCONFIG, 32'hffff_ffff, 1'b0);
    rd(`DTS_IDX_TCONFIG, 32'h2800_1058, 1'b0);
    rd(`DTS_IDX_TADDR, tAddr, 1'b0);
    foreach (zeroTab[i]) wr(zeroTab[i], 32'hffff_ffff, 1'b0);
    foreach (zeroTab[i]) rd(zeroTab[i], 32'h0000_0000, 1'b0);
    core.fetch(1'b1, tAddr);
    settle();
    check(triggerHit, 1'b0);
    core.setMode(1'b0, 2'h3);
    settle();
    check(triggerHit, 1'b1);
    core.fetch(1'b1, tAddr + 32'h4);
    settle();
    check(triggerHit, 1'b0);
    core.fetch(1'b0, tAddr);
    core.setMode(1'b1, 2'h3);
    wr(`DTS_IDX_DBGCTRL, 32'h0000_9004, 1'b0);
    rd(`DTS_IDX_DBGCTRL, 32'h4000_9004, 1'b0);
    settle();
    check(stepEnable, 1'b1);
    check(debugPrv, 2'h0);
    wr(`DTS_IDX_DBGCTRL, 32'h0000_9006, 1'b0);
    rd(`DTS_IDX_DBGCTRL, 32'h4000_9004, 1'b0);
    core.ebreak(1'b1);
    settle();
    check(ebreakToDebug, 1'b1);
    wr(`DTS_IDX_DBGCTRL, 32'h0000_1003, 1'b0);
    settle();
    check(ebreakToDebug, 1'b0);
    core.setMode(1'b1, 2'h0);
    settle();
    check(ebreakToDebug, 1'b1);
    wr(`DTS_IDX_DBGCTRL, 32'h0000_0003, 1'b0);
    settle();
    check(ebreakToDebug, 1'b0);
    check(stepEnable, 1'b0);
    core.ebreak(1'b0);
    for (int c = 1; c < 5; c++) begin
      rnd = nextRnd(rnd);
      core.setMode(1'b0, (c == 4) ? 2'h0 : 2'h3);
      core.enter(c[2:0], rnd);
      rd(`DTS_IDX_DBGCTRL, 32'h4000_0000 | (32'(c) << 6) | ((c == 4) ? 32'h0 : 32'h3), 1'b0);
      rd(`DTS_IDX_DBGPC, rnd, 1'b0);
      settle();
      check(resumePc, rnd);
      check(debugPrv, (c == 4) ? 2'h0 : 2'h3);
    end
    foreach (dbgTab[i]) begin
      rnd = nextRnd(rnd);
      wr(dbgTab[i], rnd, 1'b0);
      rd(dbgTab[i], rnd, 1'b0);
    end
    core.setMode(1'b0, 2'h3);
    wr(`DTS_IDX_CPUCTRL, 32'hffff_ff3f, 1'b0);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_003f, 1'b0);
    settle();
    check({dummyInstrMask, dummyInstrEn, dataIndTiming, icacheEnable}, 6'h3f);
    core.pulse(1'b0);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_007f, 1'b0);
    core.pulse(1'b0);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_00ff, 1'b0);
    core.pulse(1'b1);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_00bf, 1'b0);
    wr(`DTS_IDX_CPUCTRL, 32'h0000_0000, 1'b0);
    rd(`DTS_IDX_CPUCTRL, 32'h0000_0000, 1'b0);
    settle();
    check(icacheEnable, 1'b0);
    repeat (2) @(posedge ref_clk);
    check(expQ.size(), 0);
    print_verdict();
  end
endmodule
